// File: hw/rtcrw_core.sv
// Register file, reset handling, write guard and output pin logic of the clock and calendar.
//
// How it works
// - Device reset clears alarm control; clock keeps running except after power-on reset.
// - Power-on reset leaves time and date untouched.
// - Only a seconds write clears the prescaler.
// - Watchdog reset acts like device reset.
// - Module off clears and holds sync flags.
// - Pin function drives only with output enable and on.
// - Seconds select picks seconds clock or alarm.
// - Alarm off shows initial value, else pulse.
// - Active pin function overrides the direction bit.
// - Weekday is written once, then advanced here.
// - Leap years handled for 2000 to 2099.
// - Time and date writes during a high rollover are dropped.
// - Time and date writes need write enable.
// - Write enable clears freely, sets after unlock.
// - Module off stops time from advancing.
`timescale 1ns/1ps
module rtcrw_core
  import rtcrw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic wdt_rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timebase_32k,
  input wire logic unlock_ok,
  input wire logic alarm_pulse,
  input wire logic alarm_sync_src,
  input wire logic pin_direction,
  input wire logic gpio_out,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset domains.

  logic dev_rst_n;
  logic flag_rst_n;
  rtcrw_ctrl_s ctrl;
  rtcrw_alarm_s alarm;

  // Power-on, bus and watchdog resets all act as the device reset.
  // watchdog equals device
  assign dev_rst_n = presetn & wdt_rst_n & por_n;
  // Status flags sit in reset whenever the module is off.
  // off clears flags
  assign flag_rst_n = por_n & ctrl.on;

  ////////////////////////////////////////////////////////////////////////////
  // Timebase synchroniser and tick detection.

  logic tb_s1;
  logic tb_s2;
  logic tb_s3;
  logic tb_level;
  logic tb_tick;

  // Three stages; the level follows once the second and third agree.
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      tb_s1 <= 1'b0;
      tb_s2 <= 1'b0;
      tb_s3 <= 1'b0;
      tb_level <= 1'b0;
    end
    else
    begin
      tb_s1 <= timebase_32k;
      tb_s2 <= tb_s1;
      tb_s3 <= tb_s2;
      if (tb_s2 == tb_s3)
        tb_level <= tb_s3;
    end
  end

  // One tick per rising timebase edge while the module counts.
  // off stops counting
  assign tb_tick = ctrl.on & (tb_s2 == tb_s3) & tb_s3 & ~tb_level;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.

  logic setup_phase;
  logic access_wr;
  logic hit_ctrl;
  logic hit_alarm;
  logic hit_time;
  logic hit_date;
  logic hit_atime;
  logic hit_adate;
  logic unmapped;

  assign setup_phase = psel & ~penable;
  assign access_wr = psel & penable & pready & pwrite;
  assign hit_ctrl = (paddr == CTRL_OFFSET);
  assign hit_alarm = (paddr == ALARM_CTRL_OFFSET);
  assign hit_time = (paddr == TIME_OFFSET);
  assign hit_date = (paddr == DATE_OFFSET);
  assign hit_atime = (paddr == ALARM_TIME_OFFSET);
  assign hit_adate = (paddr == ALARM_DATE_OFFSET);
  assign unmapped = ~(hit_ctrl | hit_alarm | hit_time | hit_date | hit_atime | hit_adate);

  // Byte-enable merge of write data into an old register value.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[8*i +: 8] = wd[8*i +: 8];
    return res;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler, rollover and write guard.

  logic [14:0] prescaler;
  logic time_sync_flag;
  logic half_second_flag;
  logic alarm_sync_flag;
  logic rollover;
  logic rollover_high;
  logic time_wr;
  logic date_wr;
  logic sec_wr;

  assign rollover = tb_tick & (prescaler == PRESCALE_LAST);
  // The rollover lasts while the counting clock is high at the last count.
  assign rollover_high = ctrl.on & (prescaler == PRESCALE_LAST) & tb_s3;
  assign time_wr = access_wr & hit_time & ctrl.write_enable & ~rollover_high;
  assign date_wr = access_wr & hit_date & ctrl.write_enable & ~rollover_high;
  assign sec_wr = time_wr & pstrb[TIME_SEC_LANE];

  // No reset of any kind reaches the prescaler.
  // seconds write clears
  always_ff @(posedge pclk)
  begin
    if (sec_wr)
      prescaler <= '0;
    else if (tb_tick)
      prescaler <= prescaler + 15'h0001;
  end

  // Status flags, forced low while the module is off.
  always_ff @(posedge pclk or negedge flag_rst_n)
  begin
    if (!flag_rst_n)
    begin
      time_sync_flag <= 1'b0;
      half_second_flag <= 1'b0;
      alarm_sync_flag <= 1'b0;
    end
    else
    begin
      time_sync_flag <= (prescaler >= SYNC_WINDOW_START);
      half_second_flag <= prescaler[PRESCALE_BITS-1];
      alarm_sync_flag <= alarm_sync_src;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Calendar counting.

  logic [31:0] time_reg;
  logic [31:0] date_reg;
  logic [31:0] alarm_time_reg;
  logic [31:0] alarm_date_reg;
  logic [31:0] next_time;
  logic [31:0] next_date;
  logic [7:0] last_day;
  logic leap;

  // BCD increment with wrap from top back to bottom.
  function automatic logic [7:0] bcd_inc(input logic [7:0] v, input logic [7:0] top,
                                         input logic [7:0] bottom);
    logic [7:0] res;
    res = bottom;
    if (v != top)
      res = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    return res;
  endfunction : bcd_inc

  // A two-digit BCD year is a leap year when it divides by four.
  // leap year rule
  assign leap = date_reg[28] ? (date_reg[27:24] == 4'h2 || date_reg[27:24] == 4'h6)
                : (date_reg[27:24] == 4'h0 || date_reg[27:24] == 4'h4 ||
                   date_reg[27:24] == 4'h8);

  // Last day of the current month.
  always_comb
  begin
    unique case (date_reg[23:16])
      8'h02: last_day = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  end

  // Next time and date after one second.
  always_comb
  begin
    next_time = time_reg;
    next_date = date_reg;
    next_time[15:8] = bcd_inc(time_reg[15:8], 8'h59, 8'h00);
    if (time_reg[15:8] == 8'h59)
    begin
      next_time[23:16] = bcd_inc(time_reg[23:16], 8'h59, 8'h00);
      if (time_reg[23:16] == 8'h59)
      begin
        next_time[31:24] = bcd_inc(time_reg[31:24], 8'h23, 8'h00);
        if (time_reg[31:24] == 8'h23)
        begin
          next_date[3:0] = (date_reg[3:0] == 4'h6) ? 4'h0 : date_reg[3:0] + 4'h1;
          next_date[15:8] = bcd_inc(date_reg[15:8], last_day, 8'h01);
          if (date_reg[15:8] == last_day)
          begin
            next_date[23:16] = bcd_inc(date_reg[23:16], 8'h12, 8'h01);
            if (date_reg[23:16] == 8'h12)
              next_date[31:24] = bcd_inc(date_reg[31:24], 8'h99, 8'h00);
          end
        end
      end
    end
  end

  // Time and date keep their contents through every reset.
  // untouched by reset
  always_ff @(posedge pclk)
  begin
    if (time_wr)
      time_reg <= merge(time_reg, pwdata, pstrb);
    else if (rollover)
      time_reg <= next_time;
    if (date_wr)
      date_reg <= merge(date_reg, pwdata, pstrb);
    else if (rollover)
      date_reg <= next_date;
    if (access_wr & hit_atime)
      alarm_time_reg <= merge(alarm_time_reg, pwdata, pstrb);
    if (access_wr & hit_adate)
      alarm_date_reg <= merge(alarm_date_reg, pwdata, pstrb);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control and alarm control registers.

  // Control survives bus and watchdog resets so an enabled clock keeps counting.
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
      ctrl <= '{CTRL_RESET[CTRL_ON_BIT], CTRL_RESET[CTRL_SECSEL_BIT],
                CTRL_RESET[CTRL_WREN_BIT], CTRL_RESET[CTRL_OE_BIT]};
    else if (access_wr & hit_ctrl)
    begin
      ctrl.on <= pwdata[CTRL_ON_BIT];
      ctrl.seconds_select <= pwdata[CTRL_SECSEL_BIT];
      ctrl.pin_output_enable <= pwdata[CTRL_OE_BIT];
      ctrl.write_enable <= pwdata[CTRL_WREN_BIT] & (ctrl.write_enable | unlock_ok);
    end
  end

  always_ff @(posedge pclk or negedge dev_rst_n)
  begin
    if (!dev_rst_n)
      alarm <= '{ALARM_CTRL_RESET[ALM_EN_BIT], ALARM_CTRL_RESET[ALM_CHIME_BIT],
                 ALARM_CTRL_RESET[ALM_PIV_BIT], ALARM_CTRL_RESET[ALM_MASK_LSB +: 4],
                 ALARM_CTRL_RESET[ALM_RPT_LSB +: 8]};
    else if (access_wr & hit_alarm)
    begin
      alarm.alarm_enable <= pwdata[ALM_EN_BIT];
      alarm.chime <= pwdata[ALM_CHIME_BIT];
      alarm.pulse_initial_value <= pwdata[ALM_PIV_BIT];
      alarm.alarm_mask <= pwdata[ALM_MASK_LSB +: 4];
      alarm.repeat_count <= pwdata[ALM_RPT_LSB +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and bus answer.

  logic [31:0] ctrl_rd;
  logic [31:0] alarm_rd;
  logic [31:0] rdata;

  always_comb
  begin
    ctrl_rd = '0;
    ctrl_rd[CTRL_ON_BIT] = ctrl.on;
    ctrl_rd[CTRL_SECSEL_BIT] = ctrl.seconds_select;
    ctrl_rd[CTRL_WREN_BIT] = ctrl.write_enable;
    ctrl_rd[CTRL_TSYNC_BIT] = time_sync_flag;
    ctrl_rd[CTRL_HALF_BIT] = half_second_flag;
    ctrl_rd[CTRL_OE_BIT] = ctrl.pin_output_enable;
    alarm_rd = '0;
    alarm_rd[ALM_EN_BIT] = alarm.alarm_enable;
    alarm_rd[ALM_CHIME_BIT] = alarm.chime;
    alarm_rd[ALM_PIV_BIT] = alarm.pulse_initial_value;
    alarm_rd[ALM_SYNC_BIT] = alarm_sync_flag;
    alarm_rd[ALM_MASK_LSB +: 4] = alarm.alarm_mask;
    alarm_rd[ALM_RPT_LSB +: 8] = alarm.repeat_count;
  end

  assign rdata = hit_ctrl ? ctrl_rd :
                 hit_alarm ? alarm_rd :
                 hit_time ? time_reg :
                 hit_date ? date_reg :
                 hit_atime ? alarm_time_reg :
                 hit_adate ? alarm_date_reg : 32'h0000_0000;

  // Answer is prepared in the setup cycle and shown in the access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup_phase;
      pslverr <= setup_phase & unmapped;
      prdata <= (setup_phase & ~pwrite) ? rdata : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pin.

  logic pin_active;
  logic pin_func;

  assign pin_active = ctrl.on & ctrl.pin_output_enable;
  assign pin_func = ctrl.seconds_select ? half_second_flag :
                    (alarm.alarm_enable ? alarm_pulse : alarm.pulse_initial_value);

  // Active pin function overrides the general-purpose direction; enable low drives.
  // direction overridden
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
    begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
    end
    else
    begin
      pin_out <= pin_active ? pin_func : gpio_out;
      pin_oe_n <= pin_active ? 1'b0 : pin_direction;
    end
  end

endmodule : rtcrw_core

// File: common/rtcrw_pkg.sv
// Package with register map, field layouts and timing constants of the clock guard block.
package rtcrw_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] ALARM_CTRL_OFFSET = 8'h10;
  localparam logic [7:0] TIME_OFFSET = 8'h20;
  localparam logic [7:0] DATE_OFFSET = 8'h30;
  localparam logic [7:0] ALARM_TIME_OFFSET = 8'h40;
  localparam logic [7:0] ALARM_DATE_OFFSET = 8'h50;

  // Field positions of the clock control register.
  localparam int CTRL_ON_BIT = 15;
  localparam int CTRL_SECSEL_BIT = 7;
  localparam int CTRL_WREN_BIT = 3;
  localparam int CTRL_TSYNC_BIT = 2;
  localparam int CTRL_HALF_BIT = 1;
  localparam int CTRL_OE_BIT = 0;

  // Field positions of the alarm control register.
  localparam int ALM_EN_BIT = 15;
  localparam int ALM_CHIME_BIT = 14;
  localparam int ALM_PIV_BIT = 13;
  localparam int ALM_SYNC_BIT = 12;
  localparam int ALM_MASK_LSB = 8;
  localparam int ALM_RPT_LSB = 0;

  // Seconds byte lane of the time register.
  localparam int TIME_SEC_LANE = 1;

  // Reset values.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] ALARM_CTRL_RESET = 32'h0000_0000;

  // Timebase: 32768 ticks a second; the sync window spans the last ticks before a rollover.
  localparam int PRESCALE_BITS = 15;
  localparam logic [14:0] PRESCALE_LAST = 15'h7FFF;
  localparam logic [14:0] SYNC_WINDOW_START = 15'h7FE0;

  // Control bits held by the control register.
  typedef struct packed {
    logic on;
    logic seconds_select;
    logic write_enable;
    logic pin_output_enable;
  } rtcrw_ctrl_s;

  // Writable fields of the alarm control register.
  typedef struct packed {
    logic alarm_enable;
    logic chime;
    logic pulse_initial_value;
    logic [3:0] alarm_mask;
    logic [7:0] repeat_count;
  } rtcrw_alarm_s;

endpackage : rtcrw_pkg

// File: testbench/rtcrw_core_asserts.sv
// Checker of bus and pin timing at the ports of the clock guard block.
`timescale 1ns/1ps
module rtcrw_core_asserts
  import rtcrw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pin_direction,
  input wire logic gpio_out,
  input wire logic pin_out,
  input wire logic pin_oe_n
);
  // Release of both resets, setup cycle, and a hit on a mapped register.
  wire up = presetn & por_n;
  wire setup = psel & ~penable;
  wire map = paddr == CTRL_OFFSET || paddr == ALARM_CTRL_OFFSET || paddr == TIME_OFFSET
    || paddr == DATE_OFFSET || paddr == ALARM_TIME_OFFSET || paddr == ALARM_DATE_OFFSET;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!up);
  ////////////////////////////////
  // Bus answer and pin release properties.
  a_ready_setup: assert property ($past(up) |-> pready == $past(setup))
    else $error("pready not one cycle after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  a_err_unmapped: assert property (setup && !map |=> pslverr)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (setup && map |=> !pslverr)
    else $error("mapped access refused");
  a_pin_released: assert property (pin_oe_n && $past(por_n) |-> $past(pin_direction) && pin_out == $past(gpio_out))
    else $error("released pin not general purpose");
  a_dir_drive: assert property ($past(por_n) && !$past(pin_direction) |-> !pin_oe_n)
    else $error("pin not driven with output direction");
  c_unmapped: cover property (setup && !map);
  c_override: cover property (!pin_oe_n && pin_direction);
  c_write: cover property (pready && pwrite);
endmodule : rtcrw_core_asserts

bind rtcrw_core rtcrw_core_asserts i_chk (.pclk, .presetn, .por_n, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .pin_direction, .gpio_out, .pin_out, .pin_oe_n);

// File: testbench/rtcrw_core_tb_top.sv
// Self-checking bench of the clock guard block over its register bus and pin.
`timescale 1ns/1ps
module rtcrw_core_tb_top
  import rtcrw_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, por_n = 1'b0, wdt_rst_n = 1'b0, unlock_ok = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, alarm_pulse = 1'b0, alarm_sync_src = 1'b0;
  logic pin_direction = 1'b1, gpio_out = 1'b0, pready, pslverr, pin_out, pin_oe_n, er;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [2:0] tb_cnt = 3'h0;
  int n_mismatch = 0, check_count = 0;
  localparam logic [31:0] T0 = 32'h1615_3300;
  localparam logic [31:0] D0 = 32'h0610_2705;

  // Clock and a fast timebase of eight clock periods.
  always #2 pclk = ~pclk;
  always @(posedge pclk) tb_cnt <= tb_cnt + 3'h1;

  rtcrw_core i_dut (.pclk(pclk), .presetn(presetn), .por_n(por_n), .wdt_rst_n(wdt_rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timebase_32k(tb_cnt[2]), .unlock_ok(unlock_ok), .alarm_pulse(alarm_pulse),
    .alarm_sync_src(alarm_sync_src), .pin_direction(pin_direction), .gpio_out(gpio_out),
    .pin_in(1'b0), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  ////////////////////////////////
  // Compare, bus cycle, pin and closing tasks.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a wait that gets no answer.
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, nm);
  endtask : rdchk

  task automatic pin(input logic oe_n, input logic v);
    repeat (2) @(posedge pclk);
    chk({31'h0, pin_oe_n}, {31'h0, oe_n}, "pin_oe_n");
    chk({31'h0, pin_out}, {31'h0, v}, "pin_out");
  endtask : pin

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  ////////////////////////////////
  // Watchdog that cuts a hang short.
  initial
  begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    finish_test();
  end

  // Main test sequence.
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    wdt_rst_n <= 1'b1;
    @(posedge pclk);
    rdchk(ALARM_CTRL_OFFSET, ALARM_CTRL_RESET, "alarm reset");
    rdchk(CTRL_OFFSET, CTRL_RESET, "ctrl flags off");
    rdchk(8'h60, 32'h0, "unmapped data");
    chk({31'h0, er}, 32'h1, "unmapped pslverr");
    $display("Test reset finished");
    apb(1'b1, CTRL_OFFSET, 32'h8);
    rdchk(CTRL_OFFSET, 32'h0, "locked wren");
    unlock_ok <= 1'b1;
    apb(1'b1, CTRL_OFFSET, 32'h8);
    unlock_ok <= 1'b0;
    rdchk(CTRL_OFFSET, 32'h8, "unlocked wren");
    apb(1'b1, TIME_OFFSET, T0);
    apb(1'b1, DATE_OFFSET, D0);
    rdchk(TIME_OFFSET, T0, "time off");
    rdchk(TIME_OFFSET, T0, "time reread");
    rdchk(DATE_OFFSET, D0, "date weekday");
    apb(1'b1, ALARM_TIME_OFFSET, 32'h1615_4300);
    rdchk(ALARM_TIME_OFFSET, 32'h1615_4300, "alarm time off");
    apb(1'b1, ALARM_DATE_OFFSET, D0);
    rdchk(ALARM_DATE_OFFSET, D0, "alarm date off");
    apb(1'b1, CTRL_OFFSET, 32'h0);
    rdchk(CTRL_OFFSET, 32'h0, "wren cleared");
    apb(1'b1, TIME_OFFSET, 32'h0102_0300);
    rdchk(TIME_OFFSET, T0, "locked time");
    $display("Test write lock finished");
    alarm_sync_src <= 1'b1;
    apb(1'b1, ALARM_CTRL_OFFSET, 32'hFFFF_FFFF);
    rdchk(ALARM_CTRL_OFFSET, 32'h0000_EFFF, "alarm sync off");
    apb(1'b1, CTRL_OFFSET, 32'h8000);
    rdchk(ALARM_CTRL_OFFSET, 32'h0000_FFFF, "alarm sync on");
    // Alarm-sync low again so later alarm control reads show the sync flag clear.
    alarm_sync_src <= 1'b0;
    wdt_rst_n <= 1'b0;
    @(posedge pclk);
    wdt_rst_n <= 1'b1;
    @(posedge pclk);
    rdchk(ALARM_CTRL_OFFSET, 32'h0, "watchdog alarm");
    rdchk(CTRL_OFFSET, 32'h8000, "watchdog on");
    apb(1'b1, ALARM_CTRL_OFFSET, 32'hFFFF);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(ALARM_CTRL_OFFSET, 32'h0, "reset alarm");
    rdchk(CTRL_OFFSET, 32'h8000, "reset on");
    por_n <= 1'b0;
    @(posedge pclk);
    por_n <= 1'b1;
    @(posedge pclk);
    rdchk(CTRL_OFFSET, 32'h0, "power-on ctrl");
    rdchk(TIME_OFFSET, T0, "power-on time");
    $display("Test resets finished");
    gpio_out <= 1'b1;
    apb(1'b1, CTRL_OFFSET, 32'h1);
    pin(1'b1, 1'b1);
    apb(1'b1, ALARM_CTRL_OFFSET, 32'h2000);
    apb(1'b1, CTRL_OFFSET, 32'h8001);
    pin(1'b0, 1'b1);
    apb(1'b1, ALARM_CTRL_OFFSET, 32'h0);
    pin(1'b0, 1'b0);
    apb(1'b1, ALARM_CTRL_OFFSET, 32'h8000);
    alarm_pulse <= 1'b1;
    pin(1'b0, 1'b1);
    apb(1'b1, CTRL_OFFSET, 32'h8081);
    pin(1'b0, 1'b0);
    apb(1'b1, CTRL_OFFSET, 32'h0081);
    pin(1'b1, 1'b1);
    pin_direction <= 1'b0;
    gpio_out <= 1'b0;
    pin(1'b0, 1'b0);
    $display("Test pin finished");
    finish_test();
  end
endmodule : rtcrw_core_tb_top
